// >>> cstw_params.svh
/*
  Offsets, field positions, reset values and timing counts of the clock
  source and timewheel block. Assumes a 200 MHz system clock and an APB master.
*/
//
// Behaviour
// - Slow timewheel: 13-bit counter on 1 kHz tick.
// - Slow timewheel stops in hibernate or debug halt.
// - Firmware can clear the slow timewheel.
// - Slow timewheel gives periodic wakeups, optional interrupt.
// - Fast timewheel: 5-bit counter, programmable terminal count.
// - Fast timewheel reloads itself at terminal count.
// - Fast timewheel terminal count optionally raises interrupt.
// - 33 kHz clock is 100 kHz divided by three.
// - Divided oscillator outputs have 50% duty cycle; odd divider ratios give a high time of half the ratio rounded down.
// - Low-speed oscillator gives 1, 33, 100 kHz clocks.
// - Main oscillator offers six frequencies, each trimmed.
// - Doubler makes 48 MHz from 24 MHz, selectable source.
// - PLL 24-80 MHz, 4032 divider ratios.
// - PLL locks within 250 us, readable lock bit.
// - PLL lock is a routable output signal.
// - Eight digital, four analog, one bus 16-bit divider.
// - Main oscillator USB mode locks to USB timing.
// - Divider: 8-input mux, divide by two or more.
`ifndef CSTW_PARAMS_SVH
`define CSTW_PARAMS_SVH

`define CSTW_CLK_SYS_MHZ 200
`define CSTW_LP_HALF_NS 5000
`define CSTW_LP_HALF_CYC ((`CSTW_LP_HALF_NS * `CSTW_CLK_SYS_MHZ) / 1000)
`define CSTW_DIV3_HALVES 3
`define CSTW_SLOW_HALVES 100
`define CSTW_PLL_LOCK_US 250
`define CSTW_PLL_LOCK_CYC (`CSTW_PLL_LOCK_US * `CSTW_CLK_SYS_MHZ)

`define CSTW_OFS_CTRL 12'h000
`define CSTW_OFS_PLL_DIV 12'h004
`define CSTW_OFS_SLOW_CTL 12'h008
`define CSTW_OFS_FAST_CTL 12'h00c
`define CSTW_OFS_STATUS 12'h010
`define CSTW_OFS_DIV_BASE 12'h040
`define CSTW_NUM_DIV 13

`define CSTW_BIT_SLOW_CLR 8
`define CSTW_MOSC_MAX 3'h5
`define CSTW_FAST_TC_RST 5'h1f
`define CSTW_DIV_RST 16'h0002
`endif

// >>> cstw_pkg.sv
/*
  Types shared by the clock source and timewheel block.
  Assumes cstw_params.svh is on the include path.
*/
package cstw_pkg;
  typedef enum logic [1:0] {
    CSTW_PLL_OFF = 2'b00,
    CSTW_PLL_LOCKING = 2'b01,
    CSTW_PLL_LOCKED = 2'b11
  } cstw_pll_st_t;

  typedef struct packed {
    logic en;
    logic [2:0] src;
    logic [15:0] div;
  } cstw_div_cfg_t;

  typedef struct packed {
    logic [2:0] mosc_freq;
    logic [7:0] mosc_trim;
    logic usb_mode;
    logic doubler_en;
    logic [1:0] doubler_src;
    logic pll_en;
    logic [1:0] pll_src;
    logic [5:0] pll_in_div;
    logic [5:0] pll_fb_div;
  } cstw_osc_ctrl_t;
endpackage

// >>> cstw_top.sv
/*
  Clock source control, thirteen clock dividers, low-speed clocks and the two
  timewheels, with an APB register slave. Assumes the analog oscillators take
  their settings from osc_ctrl and that crystal and fabric clocks arrive as
  pins far slower than clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cstw_params.svh"
module cstw_top #(
  parameter int unsigned LOCK_CYC = `CSTW_PLL_LOCK_CYC,
  parameter int unsigned SLOW_HALVES = `CSTW_SLOW_HALVES,
  parameter logic [47:0] MOSC_TRIM = 48'h605040302010
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins and power state.
  input wire logic fast_crystal_osc,
  input wire logic fabric_clk,
  input wire logic watch_crystal_osc,
  input wire logic pm_hibernate,
  input wire logic dbg_halt,
  // Generated clocks and settings.
  output cstw_pkg::cstw_osc_ctrl_t osc_ctrl,
  output logic pll_lock,
  output logic low_power_clock,
  output logic divided_low_power_clock,
  output logic slow_tick_clock,
  output logic [`CSTW_NUM_DIV-1:0] div_clk,
  // Timewheel events, one-cycle pulses.
  output logic slow_wake,
  output logic slow_irq,
  output logic fast_irq
);
  import cstw_pkg::*;

  function automatic logic [15:0] div_n(input logic [15:0] v);
    return (v < 16'h0002) ? 16'h0002 : v;
  endfunction

  function automatic logic wake_hit(input logic [12:0] c, input logic [3:0] s);
    logic [12:0] m;
    m = 13'((14'h0001 << s) - 14'h0001);
    return (c & m) == 13'h0000;
  endfunction

  // APB decode, one wait state.
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_d;
  wire acc = psel && penable;
  wire commit = acc && pready_q;
  wire is_div = (paddr >= `CSTW_OFS_DIV_BASE) && (paddr < 12'h074) && (paddr[1:0] == 2'b00);
  wire [11:0] div_ofs = paddr - `CSTW_OFS_DIV_BASE;
  wire [3:0] div_idx = div_ofs[5:2];
  wire hit_ctrl = paddr == `CSTW_OFS_CTRL;
  wire hit_pll = paddr == `CSTW_OFS_PLL_DIV;
  wire hit_slow = paddr == `CSTW_OFS_SLOW_CTL;
  wire hit_fast = paddr == `CSTW_OFS_FAST_CTL;
  wire hit_stat = paddr == `CSTW_OFS_STATUS;
  wire mapped = hit_ctrl || hit_pll || hit_slow || hit_fast || hit_stat || is_div;
  wire wr = commit && pwrite;

  // Settings.
  cstw_osc_ctrl_t osc_q;
  cstw_div_cfg_t div_cfg_q [`CSTW_NUM_DIV];
  logic [3:0] slow_int_q;
  logic slow_wake_en_q, slow_irq_en_q, fast_irq_en_q;
  logic [4:0] fast_tc_q;
  wire [2:0] freq_w = (pwdata[2:0] > `CSTW_MOSC_MAX) ? `CSTW_MOSC_MAX : pwdata[2:0];
  wire [5:0] trim_sh = 6'({freq_w, 3'b000});
  wire [7:0] trim_w = 8'(MOSC_TRIM >> trim_sh);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_q <= '0;
      slow_int_q <= 4'h0;
      slow_wake_en_q <= 1'b0;
      slow_irq_en_q <= 1'b0;
      fast_irq_en_q <= 1'b0;
      fast_tc_q <= `CSTW_FAST_TC_RST;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        osc_q.mosc_freq <= freq_w;
        osc_q.mosc_trim <= trim_w;
        osc_q.usb_mode <= pwdata[3];
        osc_q.doubler_src <= pwdata[5:4];
        osc_q.doubler_en <= pwdata[6];
        osc_q.pll_en <= pwdata[7];
        osc_q.pll_src <= pwdata[9:8];
      end
      if (hit_pll)
      begin
        osc_q.pll_in_div <= pwdata[5:0];
        osc_q.pll_fb_div <= pwdata[13:8];
      end
      if (hit_slow)
      begin
        slow_int_q <= pwdata[3:0];
        slow_wake_en_q <= pwdata[4];
        slow_irq_en_q <= pwdata[5];
      end
      if (hit_fast)
      begin
        fast_tc_q <= pwdata[4:0];
        fast_irq_en_q <= pwdata[5];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `CSTW_NUM_DIV; i++)
        div_cfg_q[i] <= '{en: 1'b0, src: 3'h0, div: `CSTW_DIV_RST};
    end
    else if (wr && is_div)
    begin
      div_cfg_q[div_idx] <= '{en: pwdata[31], src: pwdata[18:16], div: pwdata[15:0]};
    end
  end

  // Pin synchronisers; a level is taken once stages two and three agree.
  logic [2:0] s1_q, s2_q, s3_q, pin_q;
  wire [2:0] pins = {watch_crystal_osc, fabric_clk, fast_crystal_osc};
  wire [2:0] pin_agree = ~(s2_q ^ s3_q);
  wire [2:0] pin_d = (pin_agree & s3_q) | (~pin_agree & pin_q);
  wire [2:0] pin_rise = pin_d & ~pin_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      pin_q <= 3'h0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // Low-speed clocks from one prescaler of 100 kHz half periods.
  logic [11:0] pre_q;
  logic [1:0] d3_q;
  logic [6:0] sl_q;
  logic lp_q, d33_q, s1k_q;
  wire half = pre_q == 12'(`CSTW_LP_HALF_CYC - 1);
  wire d3_end = d3_q == 2'(`CSTW_DIV3_HALVES - 1);
  wire sl_end = sl_q == 7'(SLOW_HALVES - 1);
  wire lp_rise = half && !lp_q;
  wire d33_rise = half && d3_end && !d33_q;
  wire s1k_rise = half && sl_end && !s1k_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_q <= 12'h000;
      d3_q <= 2'h0;
      sl_q <= 7'h00;
      lp_q <= 1'b0;
      d33_q <= 1'b0;
      s1k_q <= 1'b0;
    end
    else
    begin
      pre_q <= half ? 12'h000 : pre_q + 12'h001;
      if (half)
      begin
        lp_q <= !lp_q;
        d3_q <= d3_end ? 2'h0 : d3_q + 2'h1;
        d33_q <= d3_end ? !d33_q : d33_q;
        sl_q <= sl_end ? 7'h00 : sl_q + 7'h01;
        s1k_q <= sl_end ? !s1k_q : s1k_q;
      end
    end
  end

  // PLL lock sequencing; a settings write after lock restarts the lock wait.
  cstw_pll_st_t pll_st_q, pll_st_d;
  logic [31:0] lock_cnt_q;
  logic lock_q;
  wire pll_touch = wr && (hit_pll || hit_ctrl);
  always_comb
  begin
    pll_st_d = pll_st_q;
    unique case (pll_st_q)
      CSTW_PLL_OFF: if (osc_q.pll_en) pll_st_d = CSTW_PLL_LOCKING;
      CSTW_PLL_LOCKING: if (lock_cnt_q >= LOCK_CYC - 1) pll_st_d = CSTW_PLL_LOCKED;
      CSTW_PLL_LOCKED: if (pll_touch) pll_st_d = CSTW_PLL_LOCKING;
      default: pll_st_d = CSTW_PLL_OFF;
    endcase
    if (!osc_q.pll_en)
      pll_st_d = CSTW_PLL_OFF;
  end
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pll_st_q <= CSTW_PLL_OFF;
      lock_cnt_q <= 32'h0;
      lock_q <= 1'b0;
    end
    else
    begin
      pll_st_q <= pll_st_d;
      lock_cnt_q <= (pll_st_d == CSTW_PLL_LOCKING && pll_st_q == CSTW_PLL_LOCKING) ? lock_cnt_q + 32'h1 : 32'h0;
      lock_q <= pll_st_d == CSTW_PLL_LOCKED;
    end
  end

  // Dividers: source 0 is clk_sys, then pins, low-speed ticks and PLL.
  wire [7:0] src_ev = {lock_q, s1k_rise, d33_rise, lp_rise, pin_rise, 1'b1};
  logic [15:0] dcnt_q [`CSTW_NUM_DIV];
  logic [15:0] dcnt_d [`CSTW_NUM_DIV];
  logic [`CSTW_NUM_DIV-1:0] dout_q, dout_d;
  always_comb
  begin
    for (int i = 0; i < `CSTW_NUM_DIV; i++)
    begin
      dcnt_d[i] = dcnt_q[i];
      dout_d[i] = dout_q[i];
      if (!div_cfg_q[i].en)
      begin
        dcnt_d[i] = 16'h0000;
        dout_d[i] = 1'b0;
      end
      else if (src_ev[div_cfg_q[i].src])
      begin
        dcnt_d[i] = (dcnt_q[i] >= div_n(div_cfg_q[i].div) - 16'h0001) ? 16'h0000 : dcnt_q[i] + 16'h0001;
        dout_d[i] = dcnt_d[i] < (div_n(div_cfg_q[i].div) >> 1);
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dout_q <= '0;
      for (int i = 0; i < `CSTW_NUM_DIV; i++)
        dcnt_q[i] <= 16'h0000;
    end
    else
    begin
      dout_q <= dout_d;
      dcnt_q <= dcnt_d;
    end
  end

  // Timewheels.
  logic [12:0] slow_q;
  logic [4:0] fast_q;
  logic sw_q, si_q, fi_q;
  wire slow_run = !pm_hibernate && !dbg_halt;
  wire slow_clr = wr && hit_slow && pwdata[`CSTW_BIT_SLOW_CLR];
  wire slow_adv = s1k_rise && slow_run;
  wire [12:0] slow_nx = slow_q + 13'h0001;
  wire slow_ev = slow_adv && !slow_clr && wake_hit(slow_nx, slow_int_q);
  // A count already past a newly lowered terminal count reloads on the next 100 kHz tick.
  wire fast_tc = lp_rise && (fast_q >= fast_tc_q);
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slow_q <= 13'h0000;
      fast_q <= 5'h00;
      sw_q <= 1'b0;
      si_q <= 1'b0;
      fi_q <= 1'b0;
    end
    else
    begin
      if (slow_clr)
        slow_q <= 13'h0000;
      else if (slow_adv)
        slow_q <= slow_nx;
      if (lp_rise)
        fast_q <= fast_tc ? 5'h00 : fast_q + 5'h01;
      sw_q <= slow_ev && slow_wake_en_q;
      si_q <= slow_ev && slow_irq_en_q;
      fi_q <= fast_tc && fast_irq_en_q;
    end
  end

  // Read data and answer.
  always_comb
  begin
    rd_d = 32'h0;
    if (hit_ctrl)
      rd_d = {22'h0, osc_q.pll_src, osc_q.pll_en, osc_q.doubler_en, osc_q.doubler_src,
              osc_q.usb_mode, osc_q.mosc_freq};
    else if (hit_pll)
      rd_d = {18'h0, osc_q.pll_fb_div, 2'h0, osc_q.pll_in_div};
    else if (hit_slow)
      rd_d = {26'h0, slow_irq_en_q, slow_wake_en_q, slow_int_q};
    else if (hit_fast)
      rd_d = {26'h0, fast_irq_en_q, fast_tc_q};
    else if (hit_stat)
      rd_d = {3'h0, slow_q, 3'h0, fast_q, 7'h0, lock_q};
    else if (is_div)
      rd_d = {div_cfg_q[div_idx].en, 12'h0, div_cfg_q[div_idx].src, div_cfg_q[div_idx].div};
  end
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      prdata_q <= (acc && !pready_q && !pwrite) ? rd_d : 32'h0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign osc_ctrl = osc_q;
  assign pll_lock = lock_q;
  assign low_power_clock = lp_q;
  assign divided_low_power_clock = d33_q;
  assign slow_tick_clock = s1k_q;
  assign div_clk = dout_q;
  assign slow_wake = sw_q;
  assign slow_irq = si_q;
  assign fast_irq = fi_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [31:0] en_age_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      en_age_q <= 32'h0;
    else
      en_age_q <= (osc_q.pll_en && !pll_touch) ? en_age_q + 32'h1 : 32'h0;
  end

  chk_slow_step: assert property (s1k_rise && slow_run && !slow_clr |=> slow_q == $past(slow_q) + 13'h0001)
    else $error("slow timewheel missed a tick");
  chk_slow_hold: assert property ((pm_hibernate || dbg_halt) && !slow_clr |=> $stable(slow_q))
    else $error("slow timewheel moved while stopped");
  chk_slow_clear: assert property (slow_clr |=> slow_q == 13'h0000)
    else $error("slow timewheel not cleared");
  chk_wake_pulse: assert property (slow_wake |-> $past(slow_adv) && $past(slow_wake_en_q))
    else $error("wakeup without a tick");
  chk_fast_reload: assert property (lp_rise && fast_q >= fast_tc_q |=> fast_q == 5'h00)
    else $error("fast timewheel did not reload");
  chk_fast_step: assert property (lp_rise && fast_q < fast_tc_q |=> fast_q == $past(fast_q) + 5'h01)
    else $error("fast timewheel missed a step");
  chk_fast_irq: assert property (fast_tc && fast_irq_en_q |=> fast_irq ##1 !fast_irq)
    else $error("fast interrupt not one pulse");
  chk_div3_toggle: assert property ($changed(d33_q) |-> $past(half) && $past(d3_end))
    else $error("33 kHz edge off the divide by three");
  chk_lp_half: assert property ($rose(lp_q) |-> $past(pre_q) == 12'(`CSTW_LP_HALF_CYC - 1))
    else $error("100 kHz half period wrong");
  chk_lock_off: assert property (!osc_q.pll_en |=> !pll_lock)
    else $error("lock shown while disabled");
  chk_lock_time: assert property (en_age_q > LOCK_CYC + 1 |-> pll_lock)
    else $error("lock not reached in time");
  chk_mosc_range: assert property (osc_ctrl.mosc_freq <= `CSTW_MOSC_MAX)
    else $error("main oscillator code out of range");

  cov_fast_irq: cover property (fast_irq);
  cov_slow_wake: cover property (slow_wake);
  cov_lock: cover property ($rose(pll_lock));
  cov_div_run: cover property ($rose(div_clk[0]));
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the clock source and timewheel block: register
  access, oscillator settings, PLL lock, low-speed clocks, timewheels, dividers.
  Assumes cstw_pkg and cstw_top are compiled first and cstw_params.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cstw_params.svh"
module tb_top;
  import cstw_pkg::*;
  localparam int unsigned LOCK = 50;
  // The trim table value is arbitrary.
  localparam logic [47:0] TRIM = 48'ha5b4c3d2e1f0;
  localparam int LIMIT = 99000;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err, mon;
  logic fast_crystal_osc, fabric_clk, watch_crystal_osc, pm_hibernate, dbg_halt;
  logic pll_lock, low_power_clock, divided_low_power_clock, slow_tick_clock;
  logic slow_wake, slow_irq, fast_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [`CSTW_NUM_DIV-1:0] div_clk;
  logic [4:0] sel;
  cstw_osc_ctrl_t osc_ctrl;
  int bad_count, n_tests, cyc, seed, hi, per, n, k;

  cstw_top #(.LOCK_CYC(LOCK), .SLOW_HALVES(2), .MOSC_TRIM(TRIM)) cstw_top_i (
    .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fast_crystal_osc, .fabric_clk, .watch_crystal_osc, .pm_hibernate, .dbg_halt, .osc_ctrl,
    .pll_lock, .low_power_clock, .divided_low_power_clock, .slow_tick_clock, .div_clk,
    .slow_wake, .slow_irq, .fast_irq
  );

  // One monitored output at a time feeds the edge timing tasks.
  assign mon = (sel < 5'd13) ? div_clk[sel[3:0]] : (sel == 5'd13) ? low_power_clock :
    (sel == 5'd14) ? divided_low_power_clock : fast_irq;

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Pin clocks keep moving so the synchronisers see real edges.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    {fast_crystal_osc, fabric_clk, watch_crystal_osc} <= {cyc[3], cyc[5], cyc[7]};
    if (cyc == LIMIT)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge clk_sys);
      w++;
    end while (pready !== 1'b1 && w < 100);
    if (w >= 100)
      bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic to_level(input logic lv, input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end while (mon !== lv && c < lim);
  endtask

  // Returns high time and full period, in clk_sys cycles, of the selected output.
  task automatic measure(input logic [4:0] s, output int h, output int p);
    int c;
    sel = s;
    to_level(1'b0, 20000, c);
    to_level(1'b1, 20000, c);
    to_level(1'b0, 20000, h);
    to_level(1'b1, 20000, p);
    p = p + h;
  endtask

  function automatic logic [31:0] trim_of(input logic [2:0] f);
    logic [2:0] c;
    c = (f > 3'h5) ? 3'h5 : f;
    return {24'h0, TRIM[8*c +: 8]};
  endfunction

  initial
  begin
    seed = 32'h21d7;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pm_hibernate = 1'b0;
    dbg_halt = 1'b0;
    {fast_crystal_osc, fabric_clk, watch_crystal_osc} = 3'h0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    sel = 5'd0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, `CSTW_OFS_FAST_CTL, 32'h0);
    chk(rd, 32'h1f);
    apb(1'b0, `CSTW_OFS_DIV_BASE + 12'h030, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `CSTW_OFS_SLOW_CTL, 32'h13f);
    apb(1'b0, `CSTW_OFS_SLOW_CTL, 32'h0);
    chk(rd, 32'h3f);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk({19'h0, rd[28:16]}, 32'h0);
    for (k = 0; k < 8; k++)
    begin
      v = $random(seed) & 32'h37f;
      v[2:0] = 3'(k);
      apb(1'b1, `CSTW_OFS_CTRL, v);
      @(posedge clk_sys);
      chk({29'h0, osc_ctrl.mosc_freq}, (k > 5) ? 32'h5 : 32'(k));
      chk({24'h0, osc_ctrl.mosc_trim}, trim_of(3'(k)));
      chk({27'h0, osc_ctrl.usb_mode, osc_ctrl.doubler_src, osc_ctrl.doubler_en, osc_ctrl.pll_en},
        {27'h0, v[3], v[5:4], v[6], 1'b0});
    end
    v = $random(seed) & 32'h3f3f;
    apb(1'b1, `CSTW_OFS_PLL_DIV, v);
    @(posedge clk_sys);
    chk({20'h0, osc_ctrl.pll_fb_div, osc_ctrl.pll_in_div}, {20'h0, v[13:8], v[5:0]});
    apb(1'b1, `CSTW_OFS_CTRL, 32'h180);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    repeat (LOCK - 10) @(posedge clk_sys);
    chk({31'h0, pll_lock}, 32'h0);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, pll_lock}, 32'h1);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b1, `CSTW_OFS_CTRL, 32'h100);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, pll_lock}, 32'h0);
    measure(5'd13, hi, per);
    chk_time(hi, 1000);
    chk_time(per, 2000);
    measure(5'd14, hi, per);
    chk_time(hi, 3000);
    chk_time(per, 6000);
    k = 1 + ($unsigned($random(seed)) % 3);
    apb(1'b1, `CSTW_OFS_FAST_CTL, 32'h20 | k);
    measure(5'd15, hi, per);
    chk_time(hi, 1);
    chk_time(per, (k + 1) * 2000);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk({31'h0, rd[12:8] <= 5'(k)}, 32'h1);
    apb(1'b1, `CSTW_OFS_FAST_CTL, 32'(k));
    sel = 5'd15;
    to_level(1'b1, (k + 2) * 2000, n);
    chk_time(n, (k + 2) * 2000);
    // Slow timewheel with a shortened tick: wake every second count, then stop it.
    apb(1'b1, `CSTW_OFS_SLOW_CTL, 32'h131);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (slow_wake !== 1'b1 && n < 9000);
    chk({31'h0, slow_wake}, 32'h1);
    chk({31'h0, slow_irq}, 32'h1);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk({31'h0, rd[16]}, 32'h0);
    chk({31'h0, rd[28:16] != 13'h0}, 32'h1);
    pm_hibernate <= 1'b1;
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    v = rd;
    repeat (5000) @(posedge clk_sys);
    apb(1'b0, `CSTW_OFS_STATUS, 32'h0);
    chk({19'h0, rd[28:16]}, {19'h0, v[28:16]});
    pm_hibernate <= 1'b0;
    for (k = 0; k < `CSTW_NUM_DIV; k++)
    begin
      n = (k == 1 || k == 12) ? 2 : (k == 0) ? 3 : 2 + ($unsigned($random(seed)) % 8);
      v = {1'b1, 12'h0, (k == 1) ? 3'h4 : 3'h0, 16'(n)};
      apb(1'b1, `CSTW_OFS_DIV_BASE + 12'(4 * k), v);
      apb(1'b0, `CSTW_OFS_DIV_BASE + 12'(4 * k), 32'h0);
      chk(rd, v);
      measure(5'(k), hi, per);
      chk_time(hi, (n / 2) * ((k == 1) ? 2000 : 1));
      chk_time(per, n * ((k == 1) ? 2000 : 1));
    end
    end_sim();
  end
endmodule
`default_nettype wire
